/* File: pkg/scr_pkg.sv */
// shared register map, field layout and reset values for the cal/mod register bank
package scr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_RAMP_CFG  = 8'h69;
  localparam logic [7:0]  IDX_CAL_CTRL  = 8'h6a;
  localparam logic [7:0]  IDX_UNUSED_A  = 8'h6b;
  localparam logic [7:0]  IDX_UNUSED_B  = 8'h6c;
  localparam logic [7:0]  IDX_UNUSED_C  = 8'h6d;
  localparam logic [7:0]  IDX_LOCK_CORE = 8'h6e;
  localparam logic [7:0]  IDX_CAP_TRIM  = 8'h6f;
  localparam logic [7:0]  IDX_BIAS_DAC  = 8'h70;
  localparam logic [7:0]  IDX_UNUSED_D  = 8'h71;
  localparam logic [7:0]  IDX_MOD_CTRL  = 8'h72;
  localparam logic [7:0]  IDX_DEV_SHIFT = 8'h73;
  localparam logic [7:0]  IDX_DEV_BASE  = 8'h74;
  localparam logic [7:0]  IDX_DEV_LAST  = 8'h7b;
  localparam logic [7:0]  IDX_FAST_DEV  = 8'h7c;
  localparam logic [7:0]  IDX_CAL_DIV   = 8'h80;
  // reset values
  localparam logic [15:0] RST_RAMP_CFG  = 16'h4440;
  localparam logic [15:0] RST_CAL_CTRL  = 16'h0007;
  localparam logic [15:0] RST_MOD_CTRL  = 16'h7800;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  // field positions
  localparam int RAMP_MANUAL_BIT = 5;
  localparam int DLY_CNT_LSB     = 6;
  localparam int CAL_EN_BIT      = 4;
  localparam int SCALE_LSB       = 0;
  localparam int LOCK_LSB        = 9;
  localparam int CORE_LSB        = 5;
  localparam int MOD_EN_BIT      = 10;
  localparam int FS_POL_BIT      = 8;
  localparam int SCLK_EDGE_BIT   = 7;
  localparam int LEVELS_LSB      = 5;
  localparam int DEV_SEL_LSB     = 2;
  localparam int SRC_LSB         = 0;
  localparam int DEV_SHIFT_LSB   = 3;
  // modulation sources
  typedef enum logic [1:0] {
    SCR_SRC_NONE  = 2'b00,
    SCR_SRC_AUDIO = 2'b01,
    SCR_SRC_REG   = 2'b10,
    SCR_SRC_FAST  = 2'b11
  } scr_src_t;
endpackage : scr_pkg

/* File: src/scr_cal_timer.sv */
// minimum calibration time counter for per-ramp calibration
module scr_cal_timer
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       start,
  input  wire logic [2:0] scale,
  input  wire logic [9:0] dly,
  input  wire logic [3:0] div,
  // status
  output logic            busy,
  output logic            done
);
  typedef enum logic [0:0] {
    SCR_CT_IDLE = 1'b0,
    SCR_CT_RUN  = 1'b1
  } scr_ct_t;

  scr_ct_t     state_reg;
  logic [17:0] acc_reg;
  logic [17:0] step;
  logic [17:0] target;
  logic [17:0] acc_next;

  // zero delay count treated as one to keep the time finite
  assign step     = {8'h00, (dly == 10'h000) ? 10'h001 : dly} << scale;
  assign target   = 18'h0_0001 << div;
  assign acc_next = acc_reg + step;

  // R02 time = cal period / (dly * 2^scale)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SCR_CT_IDLE;
      acc_reg   <= 18'h0_0000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        SCR_CT_IDLE: begin
          acc_reg <= 18'h0_0000;
          if (start) begin
            state_reg <= SCR_CT_RUN;
          end
        end
        SCR_CT_RUN: begin
          acc_reg <= acc_next;
          if (acc_next >= target) begin
            state_reg <= SCR_CT_IDLE;
            done      <= 1'b1;
          end
        end
        default: state_reg <= SCR_CT_IDLE;
      endcase
    end
  end

  assign busy = (state_reg == SCR_CT_RUN);
endmodule : scr_cal_timer

/* File: src/scr_mod_sel.sv */
// modulation mode decode and deviation selection
module scr_mod_sel
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control fields
  input  wire logic         global_en,
  input  wire logic [1:0]   src,
  input  wire logic [1:0]   levels,
  input  wire logic [2:0]   dev_sel,
  input  wire logic [4:0]   dev_shift,
  input  wire logic [127:0] dev_words,
  input  wire logic [15:0]  fast_word,
  // results
  output logic              mod_active,
  output logic [1:0]        mod_mode,
  output logic [46:0]       dev_applied
);
  logic [15:0] word;
  logic        act;

  always_comb begin
    word = 16'h0000;
    act  = 1'b0;
    case (scr_src_t'(src))
      SCR_SRC_AUDIO: act = global_en;
      // R12 level code zero blocks this mode
      // R13 selected stored deviation word
      SCR_SRC_REG: begin
        act  = global_en && (levels != 2'b00);
        word = dev_words[{dev_sel, 4'h0} +: 16];
      end
      // R17 fast mode uses its own word
      SCR_SRC_FAST: begin
        act  = global_en;
        word = fast_word;
      end
      default: act = 1'b0;
    endcase
  end

  // R09 global enable gates every mode
  // R18 deviation scaled by shift field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_active  <= 1'b0;
      mod_mode    <= 2'b00;
      dev_applied <= 47'h0;
    end else begin
      mod_active  <= act;
      mod_mode    <= act ? src : 2'b00;
      dev_applied <= act ? ({{31{word[15]}}, word} << dev_shift) : 47'h0;
    end
  end
endmodule : scr_mod_sel

/* File: src/scr_regs.sv */
// register bank: ramp calibration, calibration readback, modulation control
//
// Operation
// R01: ramp-start calibration bit runs calibration each automatic ramp segment; a segment start while cal_busy is high is ignored
// R02: minimum calibration time is cal period over delay count times 2^scale
// R03: software writes zero to reserved fields, 0xF pattern to mod bits 15:11
// R04: unused registers 0x6b-0x6d, 0x71 read zero, read only
// R05: lock readback bits 10:9 report tune-voltage lock state
// R06: bits 7:5 report selected oscillator core
// R07: bits 7:0 report chosen capacitor trim code
// R08: bits 8:0 report chosen bias DAC code
// R09: modulation enable bit 10 gates every modulation mode
// R10: bit 8 sets frame sync polarity in serial-audio mode
// R11: bit 7 selects serial clock edge in serial-audio mode
// R12: level field selects 2/4/8 levels; zero disables register mode
// R13: selection field picks one of eight deviation words
// R14: source field selects serial-audio, register or fast register mode
// R15: ramping mode bit picks automatic or manual ramping
// R16: eight 16-bit deviation words hold register-mode deviations
// R17: fast register mode applies dedicated fast deviation word
// R18: applied deviation scaled by two to the shift field
// R19: writes to read-only registers change nothing
//
// Local design decision: the AHB-Lite slave port.
module scr_regs
  import scr_pkg::*;
(
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // ramp engine and calibration engine
  input  wire logic        ramp_seg_start,
  input  wire logic [2:0]  core_in,
  input  wire logic [7:0]  cap_trim_in,
  input  wire logic [8:0]  bias_dac_in,
  input  wire logic [1:0]  tune_lock_pin,
  output logic             cal_start,
  output logic             cal_busy,
  // serial-audio pins
  input  wire logic        frame_sync_pin,
  input  wire logic        serial_clock_pin,
  output logic             frame_active,
  output logic             serial_sample,
  // modulation datapath
  output logic             mod_active,
  output logic [1:0]       mod_mode,
  output logic [1:0]       mod_levels,
  output logic [46:0]      dev_applied
);
  logic [15:0]  ramp_cfg_reg;
  logic [15:0]  cal_ctrl_reg;
  logic [15:0]  mod_ctrl_reg;
  logic [15:0]  dev_shift_reg;
  logic [15:0]  fast_dev_reg;
  logic [15:0]  cal_div_reg;
  logic [15:0]  dev_reg [8];
  logic [127:0] dev_flat;
  logic [2:0]   core_reg;
  logic [7:0]   cap_reg;
  logic [8:0]   bias_reg;
  logic [1:0]   lock_meta_reg;
  logic [1:0]   lock_reg;
  logic [2:0]   fs_sync_reg;
  logic [2:0]   sc_sync_reg;
  logic         wr_pend_reg;
  logic [7:0]   wr_idx_reg;
  logic         addr_ok;
  logic [7:0]   a_idx;
  logic         cal_done;
  logic         cal_req;
  logic [15:0]  rd_next;
  logic [16:0]  dwell_cnt_reg;
  logic [16:0]  dwell_lim;

  // register index from byte address
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  // read-back value for one register index
  function automatic logic [15:0] rd_value(input logic [7:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      IDX_RAMP_CFG:  v = ramp_cfg_reg;
      IDX_CAL_CTRL:  v = cal_ctrl_reg;
      // R05 live lock state
      // R06 core chosen by calibration
      IDX_LOCK_CORE: v = {5'h00, lock_reg, 1'b0, core_reg, 5'h00};
      // R07 capacitor trim readback
      IDX_CAP_TRIM:  v = {8'h00, cap_reg};
      // R08 bias dac readback
      IDX_BIAS_DAC:  v = {7'h00, bias_reg};
      IDX_MOD_CTRL:  v = mod_ctrl_reg;
      IDX_DEV_SHIFT: v = dev_shift_reg;
      IDX_FAST_DEV:  v = fast_dev_reg;
      IDX_CAL_DIV:   v = cal_div_reg;
      default: begin
        if (idx >= IDX_DEV_BASE && idx <= IDX_DEV_LAST) begin
          v = dev_reg[idx[2:0] - 3'h4];
        end
        // R04 unused and unmapped indices return zero
      end
    endcase
    return v;
  endfunction : rd_value

  // bus handshake: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;
  assign a_idx     = reg_index(haddr);

  // process form so a register change retriggers the decode, not only a new index
  always_comb begin
    rd_next = rd_value(a_idx);
  end

  // address phase capture for the following write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_idx_reg <= a_idx;
      end
    end
  end

  // read data loaded at the address phase, stands for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {16'h0000, rd_next};
    end
  end

  // writable registers; reserved bits are stored as written
  // R03 software keeps reserved patterns
  // R19 read-only indices have no write path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_cfg_reg  <= RST_RAMP_CFG;
      cal_ctrl_reg  <= RST_CAL_CTRL;
      mod_ctrl_reg  <= RST_MOD_CTRL;
      dev_shift_reg <= RST_ZERO;
      fast_dev_reg  <= RST_ZERO;
      cal_div_reg   <= RST_ZERO;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        IDX_RAMP_CFG:  ramp_cfg_reg  <= hwdata[15:0];
        IDX_CAL_CTRL:  cal_ctrl_reg  <= hwdata[15:0];
        IDX_MOD_CTRL:  mod_ctrl_reg  <= hwdata[15:0];
        IDX_DEV_SHIFT: dev_shift_reg <= hwdata[15:0];
        IDX_FAST_DEV:  fast_dev_reg  <= hwdata[15:0];
        IDX_CAL_DIV:   cal_div_reg   <= hwdata[15:0];
        default:       cal_div_reg   <= cal_div_reg;
      endcase
    end
  end

  // R16 eight stored deviation words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        dev_reg[i] <= RST_ZERO;
      end
    end else if (wr_pend_reg && wr_idx_reg >= IDX_DEV_BASE
                 && wr_idx_reg <= IDX_DEV_LAST) begin
      dev_reg[wr_idx_reg[2:0] - 3'h4] <= hwdata[15:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dev_flat[i*16 +: 16] = dev_reg[i];
    end
  end

  // pin inputs cross into hclk through two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_meta_reg <= 2'b00;
      lock_reg      <= 2'b00;
      fs_sync_reg   <= 3'b000;
      sc_sync_reg   <= 3'b000;
    end else begin
      lock_meta_reg <= tune_lock_pin;
      lock_reg      <= lock_meta_reg;
      fs_sync_reg   <= {fs_sync_reg[1:0], frame_sync_pin};
      sc_sync_reg   <= {sc_sync_reg[1:0], serial_clock_pin};
    end
  end

  // R15 manual ramping suppresses per-ramp calibration
  // R01 calibrate at each segment start when enabled and no calibration is busy
  assign cal_req = ramp_seg_start && cal_ctrl_reg[CAL_EN_BIT]
                   && !ramp_cfg_reg[RAMP_MANUAL_BIT] && !cal_busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= cal_req;
    end
  end

  // R02 calibration dwell timer
  scr_cal_timer u_cal_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (cal_req),
    .scale   (cal_ctrl_reg[SCALE_LSB +: 3]),
    .dly     (ramp_cfg_reg[DLY_CNT_LSB +: 10]),
    .div     (cal_div_reg[3:0]),
    .busy    (cal_busy),
    .done    (cal_done)
  );

  // calibration results latched when the dwell ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_reg <= 3'h0;
      cap_reg  <= 8'h00;
      bias_reg <= 9'h000;
    end else if (cal_done) begin
      core_reg <= core_in;
      cap_reg  <= cap_trim_in;
      bias_reg <= bias_dac_in;
    end
  end

  // R14 source field drives mode decode
  scr_mod_sel u_mod_sel (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .global_en   (mod_ctrl_reg[MOD_EN_BIT]),
    .src         (mod_ctrl_reg[SRC_LSB +: 2]),
    .levels      (mod_ctrl_reg[LEVELS_LSB +: 2]),
    .dev_sel     (mod_ctrl_reg[DEV_SEL_LSB +: 3]),
    .dev_shift   (dev_shift_reg[DEV_SHIFT_LSB +: 5]),
    .dev_words   (dev_flat),
    .fast_word   (fast_dev_reg),
    .mod_active  (mod_active),
    .mod_mode    (mod_mode),
    .dev_applied (dev_applied)
  );

  assign mod_levels = mod_ctrl_reg[LEVELS_LSB +: 2];

  // serial-audio sampling; only meaningful while audio mode is active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_active  <= 1'b0;
      serial_sample <= 1'b0;
    end else begin
      // R10 frame sync polarity
      frame_active <= mod_active && (mod_mode == SCR_SRC_AUDIO)
                      && (fs_sync_reg[1] ^ mod_ctrl_reg[FS_POL_BIT]);
      // R11 rising or falling serial clock edge
      serial_sample <= mod_active && (mod_mode == SCR_SRC_AUDIO)
                       && (mod_ctrl_reg[SCLK_EDGE_BIT]
                           ? (sc_sync_reg[2] && !sc_sync_reg[1])
                           : (!sc_sync_reg[2] && sc_sync_reg[1]));
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_seg_cal;
    ramp_seg_start && cal_ctrl_reg[CAL_EN_BIT] && !ramp_cfg_reg[RAMP_MANUAL_BIT] && !cal_busy;
  endsequence

  chk_cal_on_segment: assert property (s_seg_cal |=> cal_start && cal_busy) // R01
    else $error("segment start did not start calibration");

  chk_cal_manual_off: assert property (ramp_cfg_reg[RAMP_MANUAL_BIT] |=> !cal_start) // R15
    else $error("calibration started in manual ramping");

  // dwell can reach 2^15 cycles, too long for a delay range; count it instead
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwell_cnt_reg <= 17'h0_0000;
    end else begin
      dwell_cnt_reg <= cal_busy ? (dwell_cnt_reg + 17'h0_0001) : 17'h0_0000;
    end
  end

  // step is at least one, so the dwell never exceeds one cal period
  assign dwell_lim = 17'h0_0001 << cal_div_reg[3:0];

  chk_cal_dwell_end: assert property (cal_busy |-> dwell_cnt_reg < dwell_lim) // R02
    else $error("calibration dwell did not finish");

  chk_unused_zero: assert property (addr_ok && !hwrite && (a_idx == IDX_UNUSED_A
    || a_idx == IDX_UNUSED_B || a_idx == IDX_UNUSED_C
    || a_idx == IDX_UNUSED_D) |=> hrdata == 32'h0000_0000) // R04
    else $error("unused register read nonzero");

  chk_lock_readback: assert property (addr_ok && !hwrite && a_idx == IDX_LOCK_CORE
    |=> hrdata[10:9] == $past(lock_reg)) // R05
    else $error("lock readback mismatch");

  chk_trim_capture: assert property (cal_done |=> cap_reg == $past(cap_trim_in)
    && bias_reg == $past(bias_dac_in) && core_reg == $past(core_in)) // R07
    else $error("calibration result not captured");

  chk_mod_gate: assert property (!mod_ctrl_reg[MOD_EN_BIT] |=> !mod_active) // R09
    else $error("modulation active while disabled");

  chk_level_zero: assert property (mod_ctrl_reg[1:0] == SCR_SRC_REG
    && mod_ctrl_reg[LEVELS_LSB +: 2] == 2'b00 |=> !mod_active) // R12
    else $error("register mode active with zero levels");

  chk_ro_write: assert property (wr_pend_reg && wr_idx_reg == IDX_CAP_TRIM && !cal_done
    |=> $stable(cap_reg)) // R19
    else $error("write changed readback");

  chk_fast_dev: assert property (mod_ctrl_reg[MOD_EN_BIT] && mod_ctrl_reg[1:0] == SCR_SRC_FAST
    && dev_shift_reg[7:3] == 5'h00 |=> dev_applied[15:0] == $past(fast_dev_reg)) // R17
    else $error("fast deviation not applied");
endmodule : scr_regs

/* File: tb/scr_cal_model.sv */
// calibration engine stand-in: supplies results and the tune-lock level
module scr_cal_model
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // from the bank and the bench
  input  wire logic       cal_busy,
  input  wire logic [1:0] lock_val,
  // results towards the bank
  output logic [2:0]      core_in,
  output logic [7:0]      cap_trim_in,
  output logic [8:0]      bias_dac_in,
  output logic [1:0]      tune_lock_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // results only hold during calibration; outside it they wander
  // result codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_in     <= 3'h0;
      cap_trim_in <= 8'h00;
      bias_dac_in <= 9'h000;
    end else if (!cal_busy) begin
      core_in     <= 3'($urandom_range(6, 1));
      cap_trim_in <= 8'($urandom);
      bias_dac_in <= 9'($urandom);
    end
  end

  assign tune_lock_pin = lock_val;
endmodule : scr_cal_model

/* File: tb/tb_top.sv */
// self-checking bench for the cal/mod register bank
module tb_top
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        ramp_seg_start = 0, frame_sync_pin = 0, serial_clock_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0, lock_val = 0;
  logic [2:0]  hsize = 3'b010;
  wire  logic [31:0] hrdata;
  wire  logic        hreadyout, hresp, hready, cal_start, cal_busy;
  wire  logic        frame_active, serial_sample, mod_active;
  wire  logic [1:0]  mod_mode, mod_levels, tune_lock_pin;
  wire  logic [46:0] dev_applied;
  wire  logic [2:0]  core_in;
  wire  logic [7:0]  cap_trim_in;
  wire  logic [8:0]  bias_dac_in;
  int          failures = 0, n_tests = 0, cyc = 0, sel, sh;
  logic        act;
  logic [15:0] dw [8];
  logic [15:0] fw, v;
  logic [7:0]  ro [8] = '{IDX_UNUSED_A, IDX_UNUSED_B, IDX_UNUSED_C, IDX_UNUSED_D, 8'h10,
                          IDX_LOCK_CORE, IDX_CAP_TRIM, IDX_BIAS_DAC};

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  scr_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .ramp_seg_start, .core_in, .cap_trim_in, .bias_dac_in,
    .tune_lock_pin, .cal_start, .cal_busy, .frame_sync_pin, .serial_clock_pin,
    .frame_active, .serial_sample, .mod_active, .mod_mode, .mod_levels, .dev_applied);
  scr_cal_model partner (.hclk, .hresetn, .cal_busy, .lock_val, .core_in, .cap_trim_in,
    .bias_dac_in, .tune_lock_pin);

  task automatic close_out;
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input logic [46:0] got, input logic [46:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  // single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(47'(hresp), 47'h0, "response");
  endtask : bus

  function automatic int cal_len(int dv, int dl, int sc);
    int den;
    den = (dl == 0 ? 1 : dl) << sc;
    cal_len = ((1 << dv) + den - 1) / den;
  endfunction : cal_len

  function automatic logic [46:0] dev_exp(logic [15:0] w, int s);
    dev_exp = {{31{w[15]}}, w} << s;
  endfunction : dev_exp

  task automatic cal_run(input int en, input int man, input int dv, input int dl, input int sc);
    int         n, extra, go;
    logic [2:0] c;
    logic [7:0] t;
    logic [8:0] b;
    bus(1'b1, IDX_RAMP_CFG, {10'(dl), 1'(man), 5'h00});
    bus(1'b1, IDX_CAL_DIV, 16'(dv));
    bus(1'b1, IDX_CAL_CTRL, {11'h000, 1'(en), 1'b0, 3'(sc)});
    bus(1'b0, IDX_CAL_CTRL, 16'h0000);
    chk(47'(rd), 47'({en[0], 1'b0, sc[2:0]}), "cal ctrl readback");
    go = en && !man;
    n = 0;
    extra = 0;
    ramp_seg_start <= 1'b1;
    @(posedge hclk);
    ramp_seg_start <= 1'b0;
    #1;
    chk(47'(cal_start), 47'(go), "cal start");
    // a second segment start lands mid-calibration and must be ignored
    while (cal_busy === 1'b1 && n < 5000) begin
      c = core_in;
      t = cap_trim_in;
      b = bias_dac_in;
      ramp_seg_start <= (n == 1);
      @(posedge hclk);
      #1;
      n++;
      if (cal_start === 1'b1) extra++;
    end
    ramp_seg_start <= 1'b0;
    // results land one edge after busy falls; read back only after that
    @(posedge hclk);
    chk(47'(n), go ? 47'(cal_len(dv, dl, sc)) : 47'h0, "cal time");
    chk(47'(extra), 47'h0, "start while busy");
    if (go) begin
      bus(1'b0, IDX_LOCK_CORE, 16'h0000);
      chk(47'(rd), 47'({lock_val, 1'b0, c, 5'h00}), "core readback");
      bus(1'b0, IDX_CAP_TRIM, 16'h0000);
      chk(47'(rd), 47'(t), "trim readback");
      bus(1'b0, IDX_BIAS_DAC, 16'h0000);
      chk(47'(rd), 47'(b), "bias readback");
    end
  endtask : cal_run

  task automatic audio(input logic pol, input logic edg);
    int   cnt;
    logic fs;
    fs = 1'($urandom);
    bus(1'b1, IDX_MOD_CTRL, {5'h0f, 1'b1, 1'b0, pol, edg, 7'h01});
    frame_sync_pin <= fs;
    serial_clock_pin <= edg;
    repeat (6) @(posedge hclk);
    #1;
    chk(47'(frame_active), 47'(fs ^ pol), "frame sync");
    for (int h = 0; h < 2; h++) begin
      serial_clock_pin <= edg ^ (h == 0);
      cnt = 0;
      repeat (6) begin
        @(posedge hclk);
        #1;
        if (serial_sample === 1'b1) cnt++;
      end
      chk(47'(cnt), 47'(h == 0), "sample edge");
    end
  endtask : audio

  // ceiling well above the fewer than a thousand cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h7944_6dbe));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, IDX_CAL_CTRL, 16'h0000);
    chk(47'(rd), 47'(RST_CAL_CTRL), "cal ctrl reset");
    bus(1'b0, IDX_MOD_CTRL, 16'h0000);
    chk(47'(rd), 47'(RST_MOD_CTRL), "mod ctrl reset");
    for (int k = 0; k < 4; k++) begin
      lock_val <= 2'(k);
      repeat (5) @(posedge hclk);
      bus(1'b0, IDX_LOCK_CORE, 16'h0000);
      chk(47'(rd), 47'(k) << 9, "lock readback");
    end
    cal_run(1, 0, 6, 3, 1);
    cal_run(1, 0, 4, 0, 0);
    cal_run(1, 0, 0, 5, 2);
    cal_run(1, 0, 2, 1, 7);
    cal_run(0, 0, 3, 1, 0);
    cal_run(1, 1, 3, 1, 0);
    cal_run(1, 0, $urandom_range(8), $urandom_range(1023), $urandom_range(7));
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ro[i], 16'h0000);
      v = rd[15:0];
      if (i < 5) chk(47'(rd), 47'h0, "unused reads zero");
      bus(1'b1, ro[i], ~v);
      bus(1'b0, ro[i], 16'h0000);
      chk(47'(rd), 47'(v), "read-only write");
    end
    fw = 16'($urandom);
    bus(1'b1, IDX_FAST_DEV, fw);
    for (int k = 0; k < 8; k++) begin
      dw[k] = 16'($urandom);
      bus(1'b1, IDX_DEV_BASE + 8'(k), dw[k]);
    end
    for (int s = 0; s < 4; s++)
      for (int e = 0; e < 2; e++)
        for (int l = 0; l < 4; l++) begin
          sel = $urandom_range(7);
          sh = $urandom_range(31);
          v = {5'h0f, 1'(e), 3'h0, 2'(l), 3'(sel), 2'(s)};
          bus(1'b1, IDX_DEV_SHIFT, 16'(sh << 3));
          bus(1'b1, IDX_MOD_CTRL, v);
          bus(1'b0, IDX_MOD_CTRL, 16'h0000);
          chk(47'(rd), 47'(v), "mod ctrl readback");
          act = e && s != 0 && !(s == 2 && l == 0);
          chk(47'(mod_active), 47'(act), "mod active");
          chk(47'(mod_mode), act ? 47'(s) : 47'h0, "mod mode");
          chk(47'(mod_levels), 47'(l), "levels");
          if (act && s > 1)
            chk(dev_applied, dev_exp(s == 3 ? fw : dw[sel], sh), "deviation");
        end
    for (int p = 0; p < 4; p++) audio(p[1], p[0]);
    bus(1'b1, IDX_MOD_CTRL, 16'h7801);
    frame_sync_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    #1;
    chk(47'(frame_active), 47'h0, "audio disabled");
    close_out();
  end
endmodule : tb_top
